// ===== src/ecr_pkg.sv
// Purpose: Constants and types for the calibration register bank.
// Assumes: Byte-wide register port, page 0 holds all entries.
// Notes:   Float words are big-endian across four byte addresses.
package ecr_pkg;
  localparam int NUM_ENTRIES = 7;
  // Byte addresses: first byte of each entry, last entry byte, control registers, page
  localparam logic [7:0] ADDR_RATE_Y_BIAS = 8'h50;
  localparam logic [7:0] ADDR_RATE_Z_BIAS = 8'h54;
  localparam logic [7:0] ADDR_M_R1C1      = 8'h58;
  localparam logic [7:0] ADDR_M_R1C2      = 8'h5C;
  localparam logic [7:0] ADDR_M_R1C3      = 8'h60;
  localparam logic [7:0] ADDR_M_R2C1      = 8'h64;
  localparam logic [7:0] ADDR_M_R2C2      = 8'h68;
  localparam logic [7:0] ADDR_ENTRY_LAST  = 8'h6B;
  localparam logic [7:0] ADDR_CAL_ENABLE  = 8'hF0;
  localparam logic [7:0] ADDR_CAL_STATUS  = 8'hF1;
  localparam logic [7:0] PAGE_CAL         = 8'h00;
  // Entry indices
  localparam int IDX_RATE_Y = 0;
  localparam int IDX_RATE_Z = 1;
  localparam int IDX_R1C1   = 2;
  localparam int IDX_R1C2   = 3;
  localparam int IDX_R1C3   = 4;
  localparam int IDX_R2C1   = 5;
  localparam int IDX_R2C2   = 6;
  // Enable and status bit positions, enable reset value
  localparam int EN_RATE_BIT  = 0;
  localparam int EN_ACCEL_BIT = 1;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_PEND_BIT  = 1;
  localparam logic [1:0] CAL_ENABLE_RESET = 2'h0;
  // Single-precision fields and constants
  localparam logic [31:0] FP_ZERO    = 32'h0000_0000;
  localparam logic [31:0] FP_ONE     = 32'h3F80_0000;
  localparam logic [7:0]  FP_EXP_MAX = 8'hFF;
  localparam logic [9:0]  FP_BIAS    = 10'h07F;
  localparam logic [3:0]  LANES_FULL = 4'hF;

  typedef enum {
    S_IDLE, S_RATE_Y, S_RATE_Z, S_X1, S_X2, S_X3, S_Y1, S_Y2, S_Y3
  } ecr_seq_type;
endpackage

// ===== src/ecr_fp_mul.sv
// Purpose: Combinational single-precision multiply.
// Assumes: Denormals flush to zero, NaN is not propagated.
// Notes:   Truncates rather than rounds; exact for products with 1.0.
module ecr_fp_mul (
  // Operands
  input  logic [31:0] a,
  input  logic [31:0] b,
  // Result
  output logic [31:0] prod
);
  import ecr_pkg::*;

  logic        sgn;
  logic [47:0] mp;
  logic [9:0]  ex;

  assign sgn = a[31] ^ b[31];
  assign mp  = {1'b1, a[22:0]} * {1'b1, b[22:0]};

  always_comb begin
    ex = {2'b00, a[30:23]} + {2'b00, b[30:23]} - FP_BIAS;
    if (mp[47]) begin
      ex = ex + 10'd1;
    end
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
      prod = {sgn, 31'h0};
    end else if (ex[9] || ex == 10'd0) begin
      prod = {sgn, 31'h0};
    end else if (ex >= {2'b00, FP_EXP_MAX}) begin
      // Saturate to infinity on overflow
      prod = {sgn, FP_EXP_MAX, 23'h0};
    end else if (mp[47]) begin
      prod = {sgn, ex[7:0], mp[46:24]};
    end else begin
      prod = {sgn, ex[7:0], mp[45:23]};
    end
  end
endmodule // ecr_fp_mul

// ===== src/ecr_fp_add.sv
// Purpose: Combinational single-precision add.
// Assumes: Denormals flush to zero, NaN is not propagated.
// Notes:   Adding a zero returns the other operand bit for bit; two zeros give plus zero.
module ecr_fp_add (
  // Operands
  input  logic [31:0] a,
  input  logic [31:0] b,
  // Result
  output logic [31:0] sum
);
  import ecr_pkg::*;

  logic        a_big;
  logic [31:0] big;
  logic [31:0] sml;
  logic [7:0]  diff;
  logic [23:0] ms;

  assign a_big = a[30:0] >= b[30:0];
  assign big   = a_big ? a : b;
  assign sml   = a_big ? b : a;
  assign diff  = big[30:23] - sml[30:23];
  assign ms    = (diff > 8'd23) ? 24'h0 : ({1'b1, sml[22:0]} >> diff);

  always_comb begin
    logic [24:0] s;
    logic [4:0]  lz;
    logic        found;
    logic [9:0]  ex;
    logic [23:0] mn;
    s = 25'h0;
    lz = 5'd0;
    found = 1'b0;
    ex = {2'b00, big[30:23]};
    mn = 24'h0;
    if (a[30:23] == 8'h00) begin
      sum = (b[30:23] == 8'h00) ? FP_ZERO : b;
    end else if (b[30:23] == 8'h00) begin
      sum = a;
    end else if (big[31] == sml[31]) begin
      s = {1'b0, 1'b1, big[22:0]} + {1'b0, ms};
      if (s[24]) begin
        ex = ex + 10'd1;
        mn = s[24:1];
      end else begin
        mn = s[23:0];
      end
      if (ex >= {2'b00, FP_EXP_MAX}) begin
        sum = {big[31], FP_EXP_MAX, 23'h0};
      end else begin
        sum = {big[31], ex[7:0], mn[22:0]};
      end
    end else begin
      s = {1'b0, 1'b1, big[22:0]} - {1'b0, ms};
      for (int i = 23; i >= 0; i--) begin
        if (!found && s[i]) begin
          found = 1'b1;
          lz = 5'(23 - i);
        end
      end
      mn = s[23:0] << lz;
      ex = ex - {5'b0, lz};
      // Cancellation to zero or underflow gives plus zero
      if (!found || ex[9] || ex == 10'd0) begin
        sum = FP_ZERO;
      end else begin
        sum = {big[31], ex[7:0], mn[22:0]};
      end
    end
  end
endmodule // ecr_fp_add

// ===== src/ecr_calib_regs.sv
// Purpose: Rate bias and accel matrix calibration bank with correction.
// Assumes: Byte register port, one-cycle read latency, 10 MHz clk.
// Notes:   Correction runs as an eight-step multiply-add sequence.
// Contract
// - Hold rate Y bias; subtract it only while rate bias enabled.
// - Hold rate Z bias; subtract it only while rate bias enabled.
// - Each four-byte entry is one single-precision float.
// - Lowest address carries bits 31:24, highest carries bits 7:0.
// - Rate biases are in degrees per second, subtracted directly.
// - Matrix corrects accel sensitivity only while accel calibration enabled.
// - Matrix elements sit row-major in consecutive four-byte slots; R2C3 comes from the accel_r2c3_in port instead.
// - Bias entries reset to float zero.
// - Matrix entries reset to identity elements.
// - Entries are readable, writable and restorable from flash backup.
// - Entries live in page zero only.
//
// The implementer's own choice: the strobed register port.
module ecr_calib_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  page,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Flash backup restore and save
  input  wire logic        nv_load_valid,
  input  wire logic [2:0]  nv_load_index,
  input  wire logic [31:0] nv_load_word,
  output logic             nv_load_ready,
  input  wire logic [2:0]  nv_save_index,
  output logic      [31:0] nv_save_word,
  // Raw sample in
  input  wire logic        sample_valid,
  output logic             sample_ready,
  input  wire logic [31:0] rate_y_in,
  input  wire logic [31:0] rate_z_in,
  input  wire logic [31:0] accel_x_in,
  input  wire logic [31:0] accel_y_in,
  input  wire logic [31:0] accel_z_in,
  input  wire logic [31:0] accel_r2c3_in,
  // Corrected sample out
  output logic             out_valid,
  output logic      [31:0] rate_y_out,
  output logic      [31:0] rate_z_out,
  output logic      [31:0] accel_x_out,
  output logic      [31:0] accel_y_out
);
  import ecr_pkg::*;

  function automatic logic [31:0] put_byte(input logic [31:0] w,
                                           input logic [1:0]  lane,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = w;
    r[8*(3-lane) +: 8] = b;
    return r;
  endfunction

  function automatic logic [7:0] get_byte(input logic [31:0] w,
                                          input logic [1:0]  lane);
    return w[8*(3-lane) +: 8];
  endfunction

  function automatic logic [31:0] reset_word(input int idx);
    return (idx == IDX_R1C1 || idx == IDX_R2C2) ? FP_ONE : FP_ZERO;
  endfunction

  logic [NUM_ENTRIES-1:0][31:0] word_r;
  logic [NUM_ENTRIES-1:0][31:0] stage_r;
  logic [NUM_ENTRIES-1:0][3:0]  mask_r;
  logic [1:0]                   cfg_r;
  logic [7:0]                   rdata_r;
  logic [31:0]                  save_r;
  ecr_seq_type                  state_r;
  ecr_seq_type                  state_nxt;
  logic [31:0]                  in_ry_r;
  logic [31:0]                  in_rz_r;
  logic [31:0]                  in_ax_r;
  logic [31:0]                  in_ay_r;
  logic [31:0]                  in_az_r;
  logic [31:0]                  in_m23_r;
  logic                         en_rate_s;
  logic                         en_acc_s;
  logic [31:0]                  acc_r;
  logic [31:0]                  ry_out_r;
  logic [31:0]                  rz_out_r;
  logic [31:0]                  ax_out_r;
  logic [31:0]                  ay_out_r;
  logic                         valid_r;

  // Address decode
  logic        page_ok;
  logic        entry_hit;
  logic [7:0]  rel;
  logic [2:0]  w_idx;
  logic [1:0]  w_lane;
  logic        wr_hit;
  logic        cfg_wr;
  logic [3:0]  lane_bit;
  logic        w_full;
  logic [31:0] stage_nxt;
  logic        pend_any;
  logic [7:0]  rd_mux;

  assign page_ok   = page == PAGE_CAL;
  assign entry_hit = page_ok && addr >= ADDR_RATE_Y_BIAS &&
                     addr <= ADDR_ENTRY_LAST;
  assign rel       = addr - ADDR_RATE_Y_BIAS;
  assign w_idx     = rel[4:2];
  assign w_lane    = rel[1:0];
  assign wr_hit    = wr && entry_hit;
  assign cfg_wr    = wr && page_ok && addr == ADDR_CAL_ENABLE;
  assign lane_bit  = 4'h1 << w_lane;
  assign stage_nxt = put_byte(stage_r[w_idx], w_lane, wdata);
  assign w_full    = (mask_r[w_idx] | lane_bit) == LANES_FULL;
  assign pend_any  = |mask_r;
  assign nv_load_ready = !wr_hit;

  always_comb begin
    if (entry_hit) begin
      rd_mux = get_byte(word_r[w_idx], w_lane);
    end else if (page_ok && addr == ADDR_CAL_ENABLE) begin
      rd_mux = {6'h0, cfg_r};
    end else if (page_ok && addr == ADDR_CAL_STATUS) begin
      rd_mux = 8'h0;
      rd_mux[ST_BUSY_BIT] = state_r != S_IDLE;
      rd_mux[ST_PEND_BIT] = pend_any;
    end else begin
      rd_mux = 8'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        word_r[i]  <= reset_word(i);
        stage_r[i] <= FP_ZERO;
        mask_r[i]  <= 4'h0;
      end
    end else if (wr_hit) begin
      stage_r[w_idx] <= stage_nxt;
      mask_r[w_idx]  <= w_full ? 4'h0 : (mask_r[w_idx] | lane_bit);
      if (w_full) begin
        word_r[w_idx] <= stage_nxt;
      end
    end else if (nv_load_valid && nv_load_index < 3'(NUM_ENTRIES)) begin
      word_r[nv_load_index] <= nv_load_word;
      mask_r[nv_load_index] <= 4'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r   <= CAL_ENABLE_RESET;
      rdata_r <= 8'h0;
      save_r  <= FP_ZERO;
    end else begin
      if (cfg_wr) begin
        cfg_r <= wdata[1:0];
      end
      rdata_r <= rd ? rd_mux : 8'h0;
      save_r  <= (nv_save_index < 3'(NUM_ENTRIES)) ?
                 word_r[nv_save_index] : FP_ZERO;
    end
  end

  assign rdata        = rdata_r;
  assign nv_save_word = save_r;

  // Correction datapath: one multiply and one add per step
  logic [31:0] coef;
  logic [31:0] oper;
  logic [31:0] prod;
  logic [31:0] add_a;
  logic [31:0] add_b;
  logic [31:0] sum;
  logic [31:0] bias;

  always_comb begin
    coef = FP_ZERO;
    oper = in_az_r;
    case (state_r)
      S_X1: begin
        coef = en_acc_s ? word_r[IDX_R1C1] : FP_ONE;
        oper = in_ax_r;
      end
      S_X2: begin
        coef = en_acc_s ? word_r[IDX_R1C2] : FP_ZERO;
        oper = in_ay_r;
      end
      S_X3: coef = en_acc_s ? word_r[IDX_R1C3] : FP_ZERO;
      S_Y1: begin
        coef = en_acc_s ? word_r[IDX_R2C1] : FP_ZERO;
        oper = in_ax_r;
      end
      S_Y2: begin
        coef = en_acc_s ? word_r[IDX_R2C2] : FP_ONE;
        oper = in_ay_r;
      end
      S_Y3: coef = en_acc_s ? in_m23_r : FP_ZERO;
      default: coef = FP_ZERO;
    endcase
  end

  // bias subtract in degrees per second
  assign bias  = !en_rate_s ? FP_ZERO :
                 (state_r == S_RATE_Y) ? word_r[IDX_RATE_Y] :
                 word_r[IDX_RATE_Z];
  assign add_a = (state_r == S_RATE_Y) ? in_ry_r :
                 (state_r == S_RATE_Z) ? in_rz_r :
                 (state_r == S_X1 || state_r == S_Y1) ? FP_ZERO : acc_r;
  assign add_b = (state_r == S_RATE_Y || state_r == S_RATE_Z) ?
                 {~bias[31], bias[30:0]} : prod;

  ecr_fp_mul u_mul (
    .a    (coef),
    .b    (oper),
    .prod (prod)
  );

  ecr_fp_add u_add (
    .a   (add_a),
    .b   (add_b),
    .sum (sum)
  );

  always_comb begin
    case (state_r)
      S_IDLE:   state_nxt = sample_valid ? S_RATE_Y : S_IDLE;
      S_RATE_Y: state_nxt = S_RATE_Z;
      S_RATE_Z: state_nxt = S_X1;
      S_X1:     state_nxt = S_X2;
      S_X2:     state_nxt = S_X3;
      S_X3:     state_nxt = S_Y1;
      S_Y1:     state_nxt = S_Y2;
      S_Y2:     state_nxt = S_Y3;
      default:  state_nxt = S_IDLE;
    endcase
  end

  assign sample_ready = state_r == S_IDLE;

  // Inputs and enables are frozen per sample so a mid-run change
  // cannot mix corrected and uncorrected terms.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= S_IDLE;
      in_ry_r   <= FP_ZERO;
      in_rz_r   <= FP_ZERO;
      in_ax_r   <= FP_ZERO;
      in_ay_r   <= FP_ZERO;
      in_az_r   <= FP_ZERO;
      in_m23_r  <= FP_ZERO;
      en_rate_s <= 1'b0;
      en_acc_s  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == S_IDLE && sample_valid) begin
        in_ry_r   <= rate_y_in;
        in_rz_r   <= rate_z_in;
        in_ax_r   <= accel_x_in;
        in_ay_r   <= accel_y_in;
        in_az_r   <= accel_z_in;
        in_m23_r  <= accel_r2c3_in;
        en_rate_s <= cfg_r[EN_RATE_BIT];
        en_acc_s  <= cfg_r[EN_ACCEL_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r    <= FP_ZERO;
      ry_out_r <= FP_ZERO;
      rz_out_r <= FP_ZERO;
      ax_out_r <= FP_ZERO;
      ay_out_r <= FP_ZERO;
      valid_r  <= 1'b0;
    end else begin
      valid_r <= state_r == S_Y3;
      case (state_r)
        S_RATE_Y: ry_out_r <= sum;
        S_RATE_Z: rz_out_r <= sum;
        S_X3:     ax_out_r <= sum;
        S_Y3:     ay_out_r <= sum;
        S_IDLE:   acc_r <= acc_r;
        default:  acc_r <= sum;
      endcase
    end
  end

  assign out_valid   = valid_r;
  assign rate_y_out  = ry_out_r;
  assign rate_z_out  = rz_out_r;
  assign accel_x_out = ax_out_r;
  assign accel_y_out = ay_out_r;

  // Checks
  logic [NUM_ENTRIES-1:0] touched_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      touched_r <= '0;
    end else if (wr_hit && w_full) begin
      touched_r[w_idx] <= 1'b1;
    end else if (nv_load_valid && nv_load_index < 3'(NUM_ENTRIES)) begin
      touched_r[nv_load_index] <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_rate_y_bypass: assert property (
    state_r == S_RATE_Y && !en_rate_s |=> rate_y_out == in_ry_r)
    else $error("rate Y changed while bias disabled");
  a_rate_z_bypass: assert property (
    state_r == S_RATE_Z && !en_rate_s |=> rate_z_out == in_rz_r)
    else $error("rate Z changed while bias disabled");
  a_rate_bias_cancel: assert property (
    state_r == S_RATE_Y && en_rate_s && in_ry_r[30:23] != 8'h00 &&
    in_ry_r == word_r[IDX_RATE_Y] |=> ##7 out_valid && rate_y_out == FP_ZERO)
    else $error("bias equal to rate did not give zero");
  a_accel_bypass: assert property (
    state_r == S_RATE_Y && !en_acc_s && in_ax_r[30:23] != 8'h00 &&
    in_ax_r[30:23] != FP_EXP_MAX |-> ##5 accel_x_out == in_ax_r)
    else $error("accel X changed while matrix disabled");
  a_byte_order: assert property (
    wr_hit && w_lane == 2'd0 |=>
    stage_r[$past(w_idx)][31:24] == $past(wdata))
    else $error("first address did not land in bits 31:24");
  a_matrix_slot: assert property (
    wr_hit && addr == ADDR_M_R2C2 + 8'd3 && w_full |=>
    word_r[IDX_R2C2][7:0] == $past(wdata))
    else $error("row 2 column 2 slot misplaced");
  a_partial_hold: assert property (
    wr_hit && !w_full |=> $stable(word_r))
    else $error("partial write reached the live word");
  a_page_guard: assert property (
    wr && !page_ok && !nv_load_valid |=> $stable(word_r) && $stable(cfg_r))
    else $error("write on another page changed state");
  a_bias_default: assert property (
    !touched_r[IDX_RATE_Y] |-> word_r[IDX_RATE_Y] == FP_ZERO)
    else $error("bias not zero before first write");
  a_matrix_default: assert property (
    !touched_r[IDX_R1C1] |-> word_r[IDX_R1C1] == FP_ONE)
    else $error("diagonal not one before first write");
  a_read_latency: assert property (
    rd && entry_hit && !nv_load_valid |=>
    rdata == get_byte(word_r[$past(w_idx)], $past(w_lane)) ##1
    (rdata == 8'h0 || $past(rd)))
    else $error("read data wrong or held too long");
  a_disabled_stable: assert property (
    !wr && !nv_load_valid |=> $stable(word_r))
    else $error("stored value changed without a write");

  c_corrected: cover property (
    state_r == S_RATE_Y && en_rate_s && en_acc_s ##8 out_valid);
  c_full_commit: cover property (wr_hit && w_full);
  c_partial: cover property (wr_hit && !w_full ##2 rd && entry_hit);
  c_restore: cover property (nv_load_valid && !wr_hit);
endmodule // ecr_calib_regs

// ===== testbench/ecr_calib_regs_bench.sv
// Purpose: Self-checking bench for the calibration register bank.
// Assumes: Byte register port, read data one cycle after the strobe.
// Notes:   Float operands are picked so every expected result is exact.
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); \
  end \
end

module ecr_calib_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ecr_pkg::*;

  localparam logic [31:0] F2 = 32'h4000_0000;
  localparam logic [31:0] F3 = 32'h4040_0000;
  localparam logic [31:0] F4 = 32'h4080_0000;

  logic        clk;
  logic        reset_n;
  logic [7:0]  page;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        nv_load_valid;
  logic [2:0]  nv_load_index;
  logic [31:0] nv_load_word;
  logic        nv_load_ready;
  logic [2:0]  nv_save_index;
  logic [31:0] nv_save_word;
  logic        sample_valid;
  logic        sample_ready;
  logic [31:0] rate_y_in;
  logic [31:0] rate_z_in;
  logic [31:0] accel_x_in;
  logic [31:0] accel_y_in;
  logic [31:0] accel_z_in;
  logic [31:0] accel_r2c3_in;
  logic        out_valid;
  logic [31:0] rate_y_out;
  logic [31:0] rate_z_out;
  logic [31:0] accel_x_out;
  logic [31:0] accel_y_out;
  int          err_total;
  int          n_tests;
  logic [31:0] model_w [NUM_ENTRIES];

  ecr_calib_regs dut_u (
    .clk(clk), .reset_n(reset_n), .page(page), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .nv_load_valid(nv_load_valid), .nv_load_index(nv_load_index),
    .nv_load_word(nv_load_word), .nv_load_ready(nv_load_ready),
    .nv_save_index(nv_save_index), .nv_save_word(nv_save_word),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .rate_y_in(rate_y_in), .rate_z_in(rate_z_in),
    .accel_x_in(accel_x_in), .accel_y_in(accel_y_in),
    .accel_z_in(accel_z_in), .accel_r2c3_in(accel_r2c3_in),
    .out_valid(out_valid), .rate_y_out(rate_y_out),
    .rate_z_out(rate_z_out), .accel_x_out(accel_x_out),
    .accel_y_out(accel_y_out)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [7:0] base_of(input int i);
    return ADDR_RATE_Y_BIAS + 8'(4 * i);
  endfunction

  function automatic logic [31:0] rst_val(input int i);
    return (i == IDX_R1C1 || i == IDX_R2C2) ? FP_ONE : FP_ZERO;
  endfunction

  // Positive normal floats only, so identity passes them bit for bit
  function automatic logic [31:0] rand_norm();
    return {1'b0, 8'h40 + 8'($urandom_range(127)), 23'($urandom)};
  endfunction

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] pg, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    page  <= pg;
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] pg, input logic [7:0] a,
                        output logic [7:0] d);
    @(posedge clk);
    page <= pg;
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rd_word(input int i, output logic [31:0] w);
    logic [7:0] b;
    for (int k = 0; k < 4; k++) begin
      bus_rd(PAGE_CAL, base_of(i) + 8'(k), b);
      w[31-8*k -: 8] = b;
    end
  endtask

  // Lane order is a parameter: the live word must wait for all four
  task automatic wr_word(input int i, input logic [31:0] w, input bit rev);
    int k;
    for (int n = 0; n < 4; n++) begin
      k = rev ? 3 - n : n;
      bus_wr(PAGE_CAL, base_of(i) + 8'(k), w[31-8*k -: 8]);
    end
  endtask

  task automatic nv_load(input int i, input logic [31:0] w);
    @(posedge clk);
    nv_load_valid <= 1'b1;
    nv_load_index <= 3'(i);
    nv_load_word  <= w;
    @(negedge clk);
    `CHK(nv_load_ready, 1'b1)
    @(posedge clk);
    nv_load_valid <= 1'b0;
    model_w[i] = w;
  endtask

  task automatic chk_save(input int i);
    @(posedge clk);
    nv_save_index <= 3'(i);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(nv_save_word, model_w[i])
  endtask

  task automatic run_sample(input logic [31:0] v [6],
                            input logic [31:0] e [4]);
    int t;
    @(posedge clk);
    rate_y_in     <= v[0];
    rate_z_in     <= v[1];
    accel_x_in    <= v[2];
    accel_y_in    <= v[3];
    accel_z_in    <= v[4];
    accel_r2c3_in <= v[5];
    sample_valid  <= 1'b1;
    @(negedge clk);
    `CHK(sample_ready, 1'b1)
    @(posedge clk);
    sample_valid <= 1'b0;
    for (t = 0; t < 20 && out_valid !== 1'b1; t++) @(negedge clk);
    if (t == 20) begin
      err_total++;
      conclude();
    end
    `CHK(rate_y_out, e[0])
    `CHK(rate_z_out, e[1])
    `CHK(accel_x_out, e[2])
    `CHK(accel_y_out, e[3])
  endtask

  initial begin
    logic [31:0] w;
    logic [7:0]  b;
    logic [31:0] cal_w [NUM_ENTRIES];
    logic [31:0] v [6];
    logic [1:0]  en;
    {reset_n, page, addr, wdata, wr, rd} = '0;
    {nv_load_valid, nv_load_index, nv_load_word, nv_save_index} = '0;
    {sample_valid, rate_y_in, rate_z_in, accel_x_in} = '0;
    {accel_y_in, accel_z_in, accel_r2c3_in} = '0;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    void'($urandom(78));
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      rd_word(i, w);
      `CHK(w, rst_val(i))
    end
    // Random words, odd entries written highest lane first
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      model_w[i] = $urandom;
      wr_word(i, model_w[i], i[0]);
      rd_word(i, w);
      `CHK(w, model_w[i])
      chk_save(i);
    end
    // Three lanes only: old word must still read back
    w = ~model_w[IDX_RATE_Z];
    for (int k = 0; k < 3; k++)
      bus_wr(PAGE_CAL, base_of(IDX_RATE_Z) + 8'(k), w[31-8*k -: 8]);
    rd_word(IDX_RATE_Z, cal_w[0]);
    `CHK(cal_w[0], model_w[IDX_RATE_Z])
    bus_rd(PAGE_CAL, ADDR_CAL_STATUS, b);
    `CHK(b[ST_PEND_BIT], 1'b1)
    bus_wr(PAGE_CAL, base_of(IDX_RATE_Z) + 8'h03, w[7:0]);
    model_w[IDX_RATE_Z] = w;
    rd_word(IDX_RATE_Z, cal_w[0]);
    `CHK(cal_w[0], w)
    bus_rd(PAGE_CAL, ADDR_CAL_STATUS, b);
    `CHK(b[ST_PEND_BIT], 1'b0)
    // Other page and unmapped places
    for (int k = 0; k < 4; k++)
      bus_wr(8'h01, base_of(0) + 8'(k), 8'($urandom));
    rd_word(0, w);
    `CHK(w, model_w[0])
    bus_rd(8'h01, base_of(0), b);
    `CHK(b, 8'h00)
    bus_wr(PAGE_CAL, 8'h6C, 8'hA5);
    bus_rd(PAGE_CAL, 8'h6C, b);
    `CHK(b, 8'h00)
    bus_rd(PAGE_CAL, 8'h4F, b);
    `CHK(b, 8'h00)
    // Restore a known bank from the flash port
    cal_w = '{FP_ONE, FP_ONE, FP_ONE, F2, FP_ZERO, FP_ZERO, FP_ONE};
    for (int i = 0; i < NUM_ENTRIES; i++) nv_load(i, cal_w[i]);
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      rd_word(i, w);
      `CHK(w, cal_w[i])
    end
    // Same-cycle bus write to an entry refuses the restore
    @(posedge clk);
    page          <= PAGE_CAL;
    addr          <= base_of(IDX_R2C1);
    wdata         <= 8'h5A;
    wr            <= 1'b1;
    nv_load_valid <= 1'b1;
    nv_load_index <= 3'(IDX_R2C1);
    nv_load_word  <= F4;
    @(negedge clk);
    `CHK(nv_load_ready, 1'b0)
    @(posedge clk);
    wr            <= 1'b0;
    nv_load_valid <= 1'b0;
    rd_word(IDX_R2C1, w);
    `CHK(w, cal_w[IDX_R2C1])
    // Disabled correction passes random inputs through
    bus_wr(PAGE_CAL, ADDR_CAL_ENABLE, 8'h00);
    for (int n = 0; n < 6; n++) v[n] = rand_norm();
    run_sample(v, '{v[0], v[1], v[2], v[3]});
    // Every enable combination with exact operands
    for (int m = 0; m < 4; m++) begin
      en = 2'(m);
      bus_wr(PAGE_CAL, ADDR_CAL_ENABLE, {6'h00, en});
      bus_rd(PAGE_CAL, ADDR_CAL_ENABLE, b);
      `CHK(b[1:0], en)
      run_sample('{F3, F4, FP_ONE, FP_ONE, FP_ONE, F2},
                 '{en[EN_RATE_BIT] ? F2 : F3, en[EN_RATE_BIT] ? F3 : F4,
                   en[EN_ACCEL_BIT] ? F3 : FP_ONE,
                   en[EN_ACCEL_BIT] ? F3 : FP_ONE});
      rd_word(IDX_RATE_Y, w);
      `CHK(w, FP_ONE)
    end
    // Bias equal to the rate input cancels to plus zero
    run_sample('{FP_ONE, FP_ONE, FP_ONE, FP_ONE, FP_ONE, F2},
               '{FP_ZERO, FP_ZERO, F3, F3});
    // Second reset after the last sample restores defaults
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd_word(IDX_R2C2, w);
    `CHK(w, FP_ONE)
    rd_word(IDX_RATE_Y, w);
    `CHK(w, FP_ZERO)
    bus_rd(PAGE_CAL, ADDR_CAL_ENABLE, b);
    `CHK(b[1:0], CAL_ENABLE_RESET)
    conclude();
  end
endmodule // ecr_calib_regs_bench
